/* core/tsr_map.svh */
// Constants for the temperature sensor serial readout: pointers, field
// positions, power-on values and conversion times.
// Assumes a 125 MHz core clock; times are converted in the top module.
`ifndef TSR_MAP_SVH
`define TSR_MAP_SVH
`define TSR_CLK_KHZ      125000
`define TSR_CONV13_MS    43
`define TSR_CONV14_MS    100
`define TSR_CONV15_MS    200
`define TSR_CONV16_MS    350
`define TSR_PTR_CTRL     3'h1
`define TSR_PTR_HIGH     3'h2
`define TSR_PTR_LOW      3'h3
`define TSR_PTR_ID       3'h7
`define TSR_CB_RW        7
`define TSR_CTL_SHDN     15
`define TSR_CTL_ONESHOT  14
`define TSR_CTL_OTRST    13
`define TSR_CTL_READY    9
`define TSR_CTL_OTSTAT   8
`define TSR_CTL_RES_HI   5
`define TSR_CTL_RES_LO   4
`define TSR_PTR_POR      8'h00
`define TSR_TEMP_POR     16'h0000
`define TSR_HIGH_POR     16'h7ff8
`define TSR_LOW_POR      16'h7ff0
// Identification value is arbitrary
`define TSR_ID_POR       16'h0a5a
`define TSR_ONESHOT_MARK 16'h8000
`define TSR_ILLEGAL_READ 16'h0000
`define TSR_BYTE_BITS    5'd8
`define TSR_WORD_BITS    5'd16
`endif

/* core/tsr_pkg.sv */
// Types shared by the temperature sensor serial readout.
// Assumes tsr_map.svh for the numeric constants.
package tsr_pkg;
	typedef enum logic [3:0] {
		TSR_IDLE = 4'b0001,
		TSR_TEMP = 4'b0010,
		TSR_CMD  = 4'b0100,
		TSR_DATA = 4'b1000
	} tsr_phase_e;

	typedef enum logic [1:0] {
		TSR_RES13 = 2'b00,
		TSR_RES14 = 2'b01,
		TSR_RES15 = 2'b10,
		TSR_RES16 = 2'b11
	} tsr_res_e;

	// Serial pins as seen from the host side
	typedef struct packed {
		logic cs_n;
		logic shift_clock;
		logic sio_in;
	} tsr_pins_s;
endpackage : tsr_pkg

/* core/tsr_sync.sv */
// Two-flop synchroniser for a bundle of asynchronous levels.
// Assumes each bit is an independent level.
`timescale 1ns/1ps
`default_nettype none
module tsr_sync #(
	parameter int           W    = 1,
	parameter logic [W-1:0] INIT = '0
) (
	// Clock and reset
	input  wire logic         clock,
	input  wire logic         rst,
	// Levels
	input  wire logic [W-1:0] d,
	output logic      [W-1:0] q
);
	logic [W-1:0] meta;

	always_ff @(posedge clock) begin
		if (rst) begin
			meta <= INIT;
			q    <= INIT;
		end else begin
			meta <= d;
			q    <= meta;
		end
	end
endmodule : tsr_sync
`default_nettype wire

/* core/tsr_conv.sv */
// Conversion timer: continuous conversions while running, single ones on request.
// Assumes the cycle count is stable during a conversion.
`timescale 1ns/1ps
`default_nettype none
module tsr_conv (
	// Clock and reset
	input  wire logic        clock,
	input  wire logic        rst,
	// Control
	input  wire logic        run,
	input  wire logic        one_shot,
	input  wire logic [25:0] cycles,
	// Status
	output logic             busy,
	output logic             os_active,
	output logic             done
);
	logic [25:0] cnt;
	logic [25:0] next_cnt;
	logic        next_busy;
	logic        next_os_active;

	// A started conversion always runs to its end, even if run drops
	always_comb begin
		next_cnt       = cnt;
		next_busy      = busy;
		next_os_active = os_active;
		done           = 1'b0;
		if (busy) begin
			if (cnt >= cycles - 26'd1) begin
				done           = 1'b1;
				next_cnt       = '0;
				next_busy      = run;
				next_os_active = 1'b0;
			end else begin
				next_cnt = cnt + 26'd1;
			end
		end else if (run || one_shot) begin
			next_busy      = 1'b1;
			next_cnt       = '0;
			next_os_active = one_shot && !run;
		end
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			cnt       <= '0;
			busy      <= 1'b0;
			os_active <= 1'b0;
		end else begin
			cnt       <= next_cnt;
			busy      <= next_busy;
			os_active <= next_os_active;
		end
	end
endmodule : tsr_conv
`default_nettype wire

/* core/tsr_top.sv */
// Temperature sensor digital core: conversions, limit alarm and 3-wire serial port.
// Assumes the analog front end presents a 16-bit reading on sensed_temp.
// Operation
// - Registers hold power-on values until written
// - One-shot in shutdown runs one conversion
// - During one-shot: flag zero, temperature 8000h
// - One-shot end sets flag, loads temperature
// - One-shot leaves other registers untouched
// - Alarm asserts when temperature exceeds upper limit
// - Alarm releases below lower limit
// - Alarm reset bit releases; next conversion re-checks
// - Shutdown or one-shot keep alarm state
// - First 16 clocks shift temperature out
// - Chip select high aborts the read
// - Then data line turns input for command
// - Command byte latched only after eighth bit
// - Partial 16-bit write stores upper byte only
// - Command and data pairs repeat freely
// - Temperature is two's complement, resolution scaled
// - 13-bit: sign D15, toggle D0, D2:D1 zero
// - Command: rw bit 7, pointer bits 2:0
// - Illegal pointer reads zero, writes nothing
// - Most significant byte and bit first
// - Shutdown waits for running conversion to finish
`timescale 1ns/1ps
`default_nettype none
`include "tsr_map.svh"
module tsr_top #(
	parameter int unsigned CONV13_CYC = `TSR_CONV13_MS * `TSR_CLK_KHZ,
	parameter int unsigned CONV14_CYC = `TSR_CONV14_MS * `TSR_CLK_KHZ,
	parameter int unsigned CONV15_CYC = `TSR_CONV15_MS * `TSR_CLK_KHZ,
	parameter int unsigned CONV16_CYC = `TSR_CONV16_MS * `TSR_CLK_KHZ
) (
	// Clock and reset
	input  wire logic              clock,
	input  wire logic              rst,
	// Serial pins
	input  wire tsr_pkg::tsr_pins_s pins,
	output logic                   sio_out,
	output logic                   sio_oe,
	// Analog front end
	input  wire logic [15:0]       sensed_temp,
	// Alarm
	output logic                   over_limit_alarm_n
);
	import tsr_pkg::*;

	tsr_pins_s  pins_s;
	logic       cs_q;
	logic       shclk_q;
	tsr_phase_e phase;
	tsr_phase_e next_phase;
	logic [4:0] bitcnt;
	logic [4:0] next_bitcnt;
	logic [15:0] shreg;
	logic [15:0] next_shreg;
	logic [7:0] ptr;
	logic [7:0] next_ptr;
	logic       next_sio_out;
	logic       next_sio_oe;
	logic       wr_hi;
	logic       wr_lo;
	logic [7:0] wr_byte;
	logic       cs_fall;
	logic       shclk_rise;
	logic       shclk_fall;
	logic       rd;
	logic       legal;
	logic [15:0] rd_val;
	logic [15:0] cmd_rd_val;

	logic       shutdown;
	logic       next_shutdown;
	tsr_res_e   res;
	tsr_res_e   next_res;
	logic [15:0] thigh;
	logic [15:0] next_thigh;
	logic [15:0] tlow;
	logic [15:0] next_tlow;
	logic [15:0] temp_reg;
	logic [15:0] next_temp_reg;
	logic       toggle;
	logic       next_toggle;
	logic       result_ready_flag;
	logic       next_result_ready_flag;
	logic       next_alarm_n;
	logic       os_req;
	logic       ot_clr;
	logic       busy;
	logic       os_active;
	logic       done;
	logic [25:0] cycles;
	logic [15:0] fmt_val;
	logic [15:0] temp_view;
	logic [15:0] ctrl_view;

	tsr_sync #(.W(3), .INIT(3'b100)) u_sync (
		.clock (clock),
		.rst   (rst),
		.d     (pins),
		.q     (pins_s)
	);

	tsr_conv u_conv (
		.clock     (clock),
		.rst       (rst),
		.run       (!shutdown),
		.one_shot  (os_req),
		.cycles    (cycles),
		.busy      (busy),
		.os_active (os_active),
		.done      (done)
	);

	function automatic logic is_legal(input logic [7:0] p);
		is_legal = (p[6:3] == 4'h0) && (p[2:0] == `TSR_PTR_CTRL || p[2:0] == `TSR_PTR_HIGH ||
			p[2:0] == `TSR_PTR_LOW || p[2:0] == `TSR_PTR_ID);
	endfunction : is_legal

	function automatic logic [15:0] reg_read(input logic [7:0] p, input logic [15:0] cv,
		input logic [15:0] hv, input logic [15:0] lv);
		reg_read = `TSR_ILLEGAL_READ;
		if (is_legal(p)) begin
			case (p[2:0])
				`TSR_PTR_CTRL: reg_read = cv;
				`TSR_PTR_HIGH: reg_read = hv;
				`TSR_PTR_LOW:  reg_read = lv;
				default:       reg_read = `TSR_ID_POR;
			endcase
		end
	endfunction : reg_read

	// Pins only reach logic after the synchroniser
	assign cs_fall    = !pins_s.cs_n && cs_q;
	assign shclk_rise = pins_s.shift_clock && !shclk_q;
	assign shclk_fall = !pins_s.shift_clock && shclk_q;
	assign rd         = ptr[`TSR_CB_RW];
	assign legal   = is_legal(ptr);

	assign temp_view = os_active ? `TSR_ONESHOT_MARK : temp_reg;
	always_comb begin
		ctrl_view                     = '0;
		ctrl_view[`TSR_CTL_SHDN]      = shutdown;
		ctrl_view[`TSR_CTL_READY]     = result_ready_flag;
		ctrl_view[`TSR_CTL_OTSTAT]    = !over_limit_alarm_n;
		ctrl_view[`TSR_CTL_RES_HI:`TSR_CTL_RES_LO] = res;
	end
	assign rd_val     = reg_read(ptr, ctrl_view, thigh, tlow);
	assign cmd_rd_val = reg_read(shreg[7:0], ctrl_view, thigh, tlow);

	// Serial engine: output changes on clock falls, input sampled on rises
	always_comb begin
		next_phase   = phase;
		next_bitcnt  = bitcnt;
		next_shreg   = shreg;
		next_ptr     = ptr;
		next_sio_out = sio_out;
		next_sio_oe  = sio_oe;
		wr_hi        = 1'b0;
		wr_lo        = 1'b0;
		wr_byte      = shreg[7:0];
		if (pins_s.cs_n) begin
			next_phase  = TSR_IDLE;
			next_bitcnt = '0;
			next_sio_oe = 1'b0;
		end else begin
			case (phase)
				TSR_IDLE: begin
					if (cs_fall) begin
						next_phase   = TSR_TEMP;
						next_shreg   = temp_view;
						next_sio_out = temp_view[15];
						next_sio_oe  = 1'b1;
						next_bitcnt  = '0;
					end
				end
				TSR_TEMP, TSR_DATA: begin
					if (phase == TSR_DATA && !rd) begin
						if (shclk_rise) begin
							next_shreg  = {shreg[14:0], pins_s.sio_in};
							next_bitcnt = bitcnt + 5'd1;
						end else if (shclk_fall && bitcnt == `TSR_BYTE_BITS) begin
							wr_hi = legal;
						end else if (shclk_fall && bitcnt == `TSR_WORD_BITS) begin
							wr_lo       = legal;
							next_phase  = TSR_CMD;
							next_bitcnt = '0;
						end
					end else if (shclk_rise) begin
						next_bitcnt = bitcnt + 5'd1;
					end else if (shclk_fall && bitcnt != 5'd0) begin
						if (bitcnt == `TSR_WORD_BITS) begin
							next_phase  = TSR_CMD;
							next_sio_oe = 1'b0;
							next_bitcnt = '0;
						end else begin
							next_shreg   = {shreg[14:0], 1'b0};
							next_sio_out = shreg[14];
						end
					end
				end
				TSR_CMD: begin
					if (shclk_rise) begin
						next_shreg  = {shreg[14:0], pins_s.sio_in};
						next_bitcnt = bitcnt + 5'd1;
					end else if (shclk_fall && bitcnt == `TSR_BYTE_BITS) begin
						next_ptr    = shreg[7:0];
						next_phase  = TSR_DATA;
						next_bitcnt = '0;
						if (shreg[`TSR_CB_RW]) begin
							next_shreg   = cmd_rd_val;
							next_sio_out = cmd_rd_val[15];
							next_sio_oe  = 1'b1;
						end
					end
				end
				default: begin
					next_phase  = TSR_IDLE;
					next_sio_oe = 1'b0;
				end
			endcase
		end
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			cs_q    <= 1'b1;
			shclk_q <= 1'b0;
			phase   <= TSR_IDLE;
			bitcnt  <= '0;
			shreg   <= '0;
			ptr     <= `TSR_PTR_POR;
			sio_out <= 1'b0;
			sio_oe  <= 1'b0;
		end else begin
			cs_q    <= pins_s.cs_n;
			shclk_q <= pins_s.shift_clock;
			phase   <= next_phase;
			bitcnt  <= next_bitcnt;
			shreg   <= next_shreg;
			ptr     <= next_ptr;
			sio_out <= next_sio_out;
			sio_oe  <= next_sio_oe;
		end
	end

	// Conversion time follows the resolution in force
	always_comb begin
		case (res)
			TSR_RES13: cycles = CONV13_CYC[25:0];
			TSR_RES14: cycles = CONV14_CYC[25:0];
			TSR_RES15: cycles = CONV15_CYC[25:0];
			default:   cycles = CONV16_CYC[25:0];
		endcase
	end

	// Unused low bits read zero, D0 carries the toggle below 16 bits
	always_comb begin
		case (res)
			TSR_RES13: fmt_val = {sensed_temp[15:3], 2'b00, !toggle};
			TSR_RES14: fmt_val = {sensed_temp[15:2], 1'b0, !toggle};
			TSR_RES15: fmt_val = {sensed_temp[15:1], !toggle};
			default:   fmt_val = sensed_temp;
		endcase
	end

	// Action bits live only in the upper byte, so they fire on its latch
	assign os_req = wr_hi && ptr[2:0] == `TSR_PTR_CTRL && wr_byte[`TSR_CTL_ONESHOT - 8] &&
		wr_byte[`TSR_CTL_SHDN - 8] && shutdown && !busy;
	assign ot_clr = wr_hi && ptr[2:0] == `TSR_PTR_CTRL && wr_byte[`TSR_CTL_OTRST - 8];

	always_comb begin
		next_shutdown = shutdown;
		next_res      = res;
		next_thigh    = thigh;
		next_tlow     = tlow;
		next_temp_reg = temp_reg;
		next_toggle   = toggle;
		next_result_ready_flag = result_ready_flag;
		next_alarm_n  = over_limit_alarm_n;
		if (wr_hi) begin
			case (ptr[2:0])
				`TSR_PTR_CTRL: next_shutdown = wr_byte[`TSR_CTL_SHDN - 8];
				`TSR_PTR_HIGH: next_thigh[15:8] = wr_byte;
				`TSR_PTR_LOW:  next_tlow[15:8]  = wr_byte;
				default: ;
			endcase
		end
		if (wr_lo) begin
			case (ptr[2:0])
				`TSR_PTR_CTRL: next_res = tsr_res_e'(wr_byte[`TSR_CTL_RES_HI:`TSR_CTL_RES_LO]);
				`TSR_PTR_HIGH: next_thigh[7:0] = wr_byte;
				`TSR_PTR_LOW:  next_tlow[7:0]  = wr_byte;
				default: ;
			endcase
		end
		if (os_req) begin
			next_result_ready_flag = 1'b0;
		end
		if (ot_clr) begin
			next_alarm_n = 1'b1;
		end
		// A finishing conversion that crosses a limit wins over a same-cycle alarm reset
		if (done) begin
			next_temp_reg = fmt_val;
			next_toggle   = !toggle;
			next_result_ready_flag = 1'b1;
			if ($signed(fmt_val) > $signed(thigh)) begin
				next_alarm_n = 1'b0;
			end else if ($signed(fmt_val) < $signed(tlow)) begin
				next_alarm_n = 1'b1;
			end
		end
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			shutdown           <= 1'b0;
			res                <= TSR_RES13;
			thigh              <= `TSR_HIGH_POR;
			tlow               <= `TSR_LOW_POR;
			temp_reg           <= `TSR_TEMP_POR;
			toggle             <= 1'b0;
			result_ready_flag  <= 1'b0;
			over_limit_alarm_n <= 1'b1;
		end else begin
			shutdown           <= next_shutdown;
			res                <= next_res;
			thigh              <= next_thigh;
			tlow               <= next_tlow;
			temp_reg           <= next_temp_reg;
			toggle             <= next_toggle;
			result_ready_flag  <= next_result_ready_flag;
			over_limit_alarm_n <= next_alarm_n;
		end
	end

	default clocking cb @(posedge clock); endclocking
	default disable iff (rst);

	property p_cmd_hold;
		(phase == TSR_CMD && bitcnt < `TSR_BYTE_BITS && pins_s.cs_n) |=> $stable(ptr);
	endproperty
	a_cmd_hold: assert property (p_cmd_hold) else $error("command byte changed on short frame");

	property p_part_write;
		(phase == TSR_DATA && !rd && pins_s.cs_n) |=> $stable(thigh) && $stable(tlow);
	endproperty
	a_part_write: assert property (p_part_write) else $error("limit changed after abort");

	property p_os_mark;
		os_active |-> (temp_view == `TSR_ONESHOT_MARK) && !result_ready_flag;
	endproperty
	a_os_mark: assert property (p_os_mark) else $error("one-shot marker missing");

	property p_os_done;
		(done && os_active) |=> result_ready_flag && !os_active && temp_reg == $past(fmt_val);
	endproperty
	a_os_done: assert property (p_os_done) else $error("one-shot result not loaded");

	property p_alarm_set;
		(done && $signed(fmt_val) > $signed(thigh)) |=> !over_limit_alarm_n;
	endproperty
	a_alarm_set: assert property (p_alarm_set) else $error("alarm not asserted above limit");

	property p_alarm_clr;
		(done && $signed(fmt_val) < $signed(tlow) && !($signed(fmt_val) > $signed(thigh)))
			|=> over_limit_alarm_n;
	endproperty
	a_alarm_clr: assert property (p_alarm_clr) else $error("alarm not released below limit");

	property p_alarm_rst;
		(ot_clr && !done) |=> over_limit_alarm_n;
	endproperty
	a_alarm_rst: assert property (p_alarm_rst) else $error("alarm reset ignored");

	property p_alarm_keep;
		(!done && !ot_clr) |=> $stable(over_limit_alarm_n);
	endproperty
	a_alarm_keep: assert property (p_alarm_keep) else $error("alarm moved without cause");

	property p_temp_drive;
		(cs_fall && phase == TSR_IDLE) |=> sio_oe && sio_out == $past(temp_view[15]);
	endproperty
	a_temp_drive: assert property (p_temp_drive) else $error("temperature not driven");

	property p_abort;
		pins_s.cs_n |=> !sio_oe && phase == TSR_IDLE;
	endproperty
	a_abort: assert property (p_abort) else $error("read not aborted");

	property p_illegal;
		(phase == TSR_DATA && rd && !legal && sio_oe) |-> !sio_out;
	endproperty
	a_illegal: assert property (p_illegal) else $error("illegal pointer read nonzero");

	c_os_done: cover property (done && os_active);
	c_write_lo: cover property (wr_lo);
	c_alarm: cover property ($fell(over_limit_alarm_n));
endmodule : tsr_top
`default_nettype wire

/* testbench/tsr_host.sv */
// Host-side serial master model for the sensor readout core.
// Assumes the bench resolves the shared data line and feeds it back on line.
`timescale 1ns/1ps
`default_nettype none
module tsr_host (
	// Clock
	input  wire logic        clock,
	// Serial pins
	output logic             cs_n,
	output logic             shift_clock,
	output logic             h_d,
	output logic             h_oe,
	input  wire logic        line,
	// Captured words
	output logic [15:0]      rd_word,
	output logic             rd_v
);
	// Half of a 160 ns link clock at 8 ns core clock
	localparam int HALF = 10;

	initial begin
		cs_n = 1'b1;
		shift_clock = 1'b0;
		h_d = 1'b0;
		h_oe = 1'b0;
		rd_word = 16'h0000;
		rd_v = 1'b0;
	end

	task automatic cyc(input int n);
		repeat (n) @(negedge clock);
	endtask : cyc

	// Data changes while the clock is low, sampled at the rise
	task automatic shift(input int n, input logic [15:0] wv, input logic drv, output logic [15:0] rv);
		rv = 16'h0000;
		h_oe = drv;
		for (int i = n - 1; i >= 0; i--) begin
			h_d = wv[i];
			cyc(HALF);
			shift_clock = 1'b1;
			rv = {rv[14:0], line};
			cyc(HALF);
			shift_clock = 1'b0;
		end
	endtask : shift

	task automatic post(input logic [15:0] w);
		rd_word = w;
		rd_v = 1'b1;
		cyc(1);
		rd_v = 1'b0;
	endtask : post

	task automatic start();
		cs_n = 1'b0;
		cyc(2 * HALF);
	endtask : start

	// Temperature always comes first in a frame
	task automatic open();
		logic [15:0] w;
		start();
		shift(16, 16'h0000, 1'b0, w);
		post(w);
	endtask : open

	task automatic cmd_rd(input logic [7:0] c);
		logic [15:0] w;
		shift(8, {8'h00, c}, 1'b1, w);
		shift(16, 16'h0000, 1'b0, w);
		post(w);
	endtask : cmd_rd

	// Fewer than 16 data bits sends only the upper part
	task automatic cmd_wr(input logic [7:0] c, input logic [15:0] wv, input int n);
		logic [15:0] w;
		shift(8, {8'h00, c}, 1'b1, w);
		shift(n, wv >> (16 - n), 1'b1, w);
	endtask : cmd_wr

	task automatic close();
		cyc(HALF);
		h_oe = 1'b0;
		cs_n = 1'b1;
		cyc(4 * HALF);
	endtask : close
endmodule : tsr_host
`default_nettype wire

/* testbench/tb_tsr_top.sv */
// Self-checking bench for the sensor readout core, host model on the serial pins.
// Assumes shortened conversion times; 16-bit long enough to see a one-shot.
`timescale 1ns/1ps
`default_nettype none
`include "tsr_map.svh"
module tb_tsr_top;
	import tsr_pkg::*;
	logic        clock;
	logic        rst;
	logic        sio_out;
	logic        sio_oe;
	logic        over_limit_alarm_n;
	logic        line;
	logic        last = 1'b0;
	logic        cs_n;
	logic        shift_clock;
	logic        h_d;
	logic        h_oe;
	logic        rd_v;
	logic [15:0] sensed_temp;
	logic [15:0] rd_word;
	logic [15:0] junk;
	logic [31:0] seed;
	logic [31:0] q[$];
	tsr_pins_s   pins;
	int          n_fail;
	int          tests_run;

	tsr_top #(.CONV13_CYC(200), .CONV14_CYC(300), .CONV15_CYC(400), .CONV16_CYC(2000)) uut (
		.clock(clock), .rst(rst), .pins(pins), .sio_out(sio_out), .sio_oe(sio_oe),
		.sensed_temp(sensed_temp), .over_limit_alarm_n(over_limit_alarm_n));
	tsr_host host (.clock(clock), .cs_n(cs_n), .shift_clock(shift_clock), .h_d(h_d), .h_oe(h_oe),
		.line(line), .rd_word(rd_word), .rd_v(rd_v));

	// Undriven line shows the inverse of its last level
	assign line = sio_oe ? sio_out : (h_oe ? h_d : ~last);
	assign pins = '{cs_n: cs_n, shift_clock: shift_clock, sio_in: line};
	always @(posedge clock) if (sio_oe | h_oe) last <= line;

	initial clock = 1'b0;
	always #4 clock = ~clock;

	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction : lfsr

	task automatic chk(input logic [15:0] exp, input logic [15:0] got, input logic [15:0] mask);
		tests_run++;
		if ((got & mask) !== (exp & mask)) begin
			n_fail++;
			$display("[ERR] t=%0t exp=%h got=%h", $time, exp, got);
		end
	endtask : chk

	task automatic chk_pin(input logic exp, input logic got);
		chk({15'h0, exp}, {15'h0, got}, 16'h0001);
	endtask : chk_pin

	task automatic expect_rd(input logic [15:0] mask, input logic [15:0] exp);
		q.push_back({mask, exp});
	endtask : expect_rd

	task automatic frame(input logic [15:0] mask, input logic [15:0] exp);
		expect_rd(mask, exp);
		host.open();
	endtask : frame

	task automatic rd(input logic [7:0] c, input logic [15:0] mask, input logic [15:0] exp);
		expect_rd(mask, exp);
		host.cmd_rd(c);
	endtask : rd

	task automatic wr1(input logic [15:0] tmask, input logic [15:0] texp, input logic [15:0] v);
		frame(tmask, texp);
		host.cmd_wr(8'h01, v, 16);
		host.close();
	endtask : wr1

	// Monitor: oldest note against each word the host captured
	always @(posedge clock) begin
		if (rd_v === 1'b1) begin
			if (q.size() == 0) begin
				n_fail++;
				$display("[ERR] t=%0t exp=%h got=%h", $time, 16'h0, rd_word);
			end else begin
				chk(q[0][15:0], rd_word, q[0][31:16]);
				void'(q.pop_front());
			end
		end
	end

	task automatic wrap_up();
		if (q.size() != 0) n_fail++;
		$display("checks %0d mismatches %0d", tests_run, n_fail);
		if (n_fail == 0 && tests_run > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask : wrap_up

	initial begin
		repeat (100000) @(posedge clock);
		n_fail++;
		wrap_up();
	end

	initial begin
		logic [15:0] st[4];
		logic        al[4];
		rst = 1'b1;
		n_fail = 0;
		tests_run = 0;
		seed = lfsr(32'hcd7044a7);
		sensed_temp = seed[15:0];
		st = '{16'h3000, 16'h1800, 16'h0400, 16'h3000};
		al = '{1'b0, 1'b0, 1'b1, 1'b0};
		repeat (3) @(posedge clock);
		@(negedge clock) rst = 1'b0;
		// Start-up shutdown hold and release
		wr1(16'hffff, `TSR_TEMP_POR, 16'h8000);
		repeat (300) @(negedge clock);
		wr1(16'hfffe, {sensed_temp[15:3], 3'h0}, 16'h0000);
		repeat (300) @(negedge clock);
		$display("startup done");
		// Power-on values, identification, illegal pointers
		frame(16'hfffe, {sensed_temp[15:3], 3'h0});
		rd(8'h81, 16'hfcff, 16'h0000);
		rd(8'h82, 16'hffff, `TSR_HIGH_POR);
		rd(8'h83, 16'hffff, `TSR_LOW_POR);
		rd(8'h87, 16'hffff, `TSR_ID_POR);
		rd(8'h80, 16'hffff, `TSR_ILLEGAL_READ);
		rd(8'h8a, 16'hffff, `TSR_ILLEGAL_READ);
		host.close();
		host.start();
		host.shift(5, 16'h0000, 1'b0, junk);
		host.close();
		chk_pin(1'b0, sio_oe);
		$display("defaults done");
		// Repeated pairs, ignored write, partial write
		frame(16'hfffe, {sensed_temp[15:3], 3'h0});
		host.cmd_wr(8'h02, 16'h1000, 16);
		host.cmd_wr(8'h03, 16'h0800, 16);
		host.cmd_wr(8'h04, 16'hffff, 16);
		rd(8'h82, 16'hffff, 16'h1000);
		rd(8'h83, 16'hffff, 16'h0800);
		host.cmd_wr(8'h02, 16'h2055, 8);
		host.close();
		frame(16'hfffe, {sensed_temp[15:3], 3'h0});
		rd(8'h82, 16'hffff, 16'h2000);
		host.close();
		$display("writes done");
		// Limit alarm with hysteresis
		for (int i = 0; i < 4; i++) begin
			sensed_temp = st[i];
			repeat (300) @(negedge clock);
			chk_pin(al[i], over_limit_alarm_n);
		end
		$display("alarm done");
		// Shutdown, alarm reset, one-shot at 16-bit
		wr1(16'hfffe, 16'h3000, 16'h8030);
		repeat (2100) @(negedge clock);
		chk_pin(1'b0, over_limit_alarm_n);
		wr1(16'hfffe, 16'h3000, 16'ha030);
		chk_pin(1'b1, over_limit_alarm_n);
		sensed_temp = 16'h3001;
		wr1(16'hfffe, 16'h3000, 16'h8030);
		frame(16'hfffe, 16'h3000);
		host.cmd_wr(8'h01, 16'hc030, 16);
		host.close();
		frame(16'hffff, `TSR_ONESHOT_MARK);
		rd(8'h81, 16'h8230, 16'h8030);
		rd(8'h82, 16'hffff, 16'h2000);
		host.close();
		chk_pin(1'b1, over_limit_alarm_n);
		repeat (2100) @(negedge clock);
		chk_pin(1'b0, over_limit_alarm_n);
		frame(16'hffff, 16'h3001);
		rd(8'h81, 16'h0200, 16'h0200);
		host.close();
		$display("one-shot done");
		wrap_up();
	end
endmodule : tb_tsr_top
`default_nettype wire
